// ### sdc_pkg.sv
package sdc_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ROW_W  = 11;
    localparam int COL_W  = 8;
    localparam int DATA_W = 16;
    localparam int OPC_W  = 12;
    localparam int PCH_MODE_BIT = 10;

    // ----------------------------------------------------------------
    // Commands as {row strobe, column strobe, write strobe}
    // ----------------------------------------------------------------
    localparam logic [2:0] CMD_ACT  = 3'h3;
    localparam logic [2:0] CMD_RD   = 3'h5;
    localparam logic [2:0] CMD_WR   = 3'h4;
    localparam logic [2:0] CMD_STOP = 3'h6;
    localparam logic [2:0] CMD_PRE  = 3'h2;
    localparam logic [2:0] CMD_REF  = 3'h1;
    localparam logic [2:0] CMD_MRS  = 3'h0;

    // ----------------------------------------------------------------
    // Mode register fields
    // ----------------------------------------------------------------
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_WB_BIT = 9;
    localparam logic [2:0] BL_ONE  = 3'h0;
    localparam logic [2:0] BL_TWO  = 3'h1;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] CL_TWO  = 3'h2;
    localparam logic [2:0] CL_THREE = 3'h3;
    localparam logic [OPC_W-1:0] MR_RESET = 12'h020;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MODE   = 8'h04;
    localparam logic [7:0] OFS_ROWS   = 8'h08;
    localparam logic [7:0] OFS_REFCNT = 8'h0C;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [3:0] {
        PWR_RUN     = 4'b0001,
        PWR_DOWN    = 4'b0010,
        PWR_SUSPEND = 4'b0100,
        PWR_SELFREF = 4'b1000
    } sdcPwr_t;

    typedef struct packed {
        logic             csN;
        logic             rasN;
        logic             casN;
        logic             weN;
        logic             bankPickBit;
        logic [ROW_W-1:0] rowAddressBus;
        logic             highByteMask;
        logic             lowByteMask;
    } sdcPins_t;

endpackage

// ### sdc_device.sv
`timescale 1ns/100ps

module sdc_device
    import sdc_pkg::*;
#(
    parameter int ROWS_W = ROW_W,
    parameter int COLS_W = COL_W
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              cke,
    input  wire sdcPins_t          pins,
    input  wire logic [DATA_W-1:0] dataIn,
    output logic      [DATA_W-1:0] dataOut,
    output logic      [1:0]        dataOe,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp
);

    // ----------------------------------------------------------------
    // Clock gate and command decode
    // ----------------------------------------------------------------
    logic               cke_q;
    logic               edgeOk;
    logic               cmdValid;
    logic [2:0]         cmd;
    logic               isAct, isRd, isWr, isStop, isPre, isRef, isMrs;
    logic [OPC_W-1:0]   mode_q;
    logic [1:0]         bankOpen_q;
    logic [ROWS_W-1:0]  bankRow_q [2];
    sdcPwr_t            pwr_q;
    logic [15:0]        refCnt_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cke_q <= 1'b1;
        end else begin
            cke_q <= cke;
        end
    end

    assign edgeOk   = cke_q;
    assign cmdValid = edgeOk && !pins.csN;
    assign cmd    = {pins.rasN, pins.casN, pins.weN};
    assign isAct  = cmdValid && (cmd == CMD_ACT);
    assign isRd   = cmdValid && (cmd == CMD_RD);
    assign isWr   = cmdValid && (cmd == CMD_WR);
    assign isStop = cmdValid && (cmd == CMD_STOP);
    assign isPre  = cmdValid && (cmd == CMD_PRE);
    assign isRef  = cmdValid && (cmd == CMD_REF);
    assign isMrs  = cmdValid && (cmd == CMD_MRS);

    // ----------------------------------------------------------------
    // Burst helpers
    // ----------------------------------------------------------------
    function automatic logic [8:0] burstLen(input logic [2:0] code);
        case (code)
            BL_ONE:   burstLen = 9'h001;
            BL_TWO:   burstLen = 9'h002;
            BL_FOUR:  burstLen = 9'h004;
            BL_EIGHT: burstLen = 9'h008;
            default:  burstLen = 9'h000;
        endcase
    endfunction

    // Full page always wraps sequentially; interleave only makes sense
    // inside a power-of-two block.
    function automatic logic [COLS_W-1:0] burstCol(input logic [COLS_W-1:0] c0,
                                                    input logic [COLS_W-1:0] n,
                                                    input logic [8:0]        len,
                                                    input logic              ilv);
        logic [COLS_W-1:0] wrap;
        wrap = (len == 9'h000) ? '1 : COLS_W'(len - 9'h001);
        if (ilv && len != 9'h000) begin
            burstCol = (c0 & ~wrap) | ((c0 ^ n) & wrap);
        end else begin
            burstCol = (c0 & ~wrap) | ((c0 + n) & wrap);
        end
    endfunction

    // ----------------------------------------------------------------
    // Burst engine
    // ----------------------------------------------------------------
    logic               burstOn_q, burstWr_q, burstBank_q, burstAp_q, burstIlv_q;
    logic [COLS_W-1:0]  burstCol0_q, burstCnt_q;
    logic [8:0]         burstLen_q;
    logic               beatGo, beatWr, beatBank, beatAp, beatIlv, lastBeat;
    logic [COLS_W-1:0]  beatCol0, beatCnt, beatCol;
    logic [8:0]         beatLen;
    logic               apFire;

    always_comb begin
        beatGo   = 1'b0;
        beatWr   = burstWr_q;
        beatBank = burstBank_q;
        beatCol0 = burstCol0_q;
        beatCnt  = burstCnt_q;
        beatLen  = burstLen_q;
        beatAp   = burstAp_q;
        beatIlv  = burstIlv_q;
        // column from low address bits; any cycle
        if (isRd || isWr) begin
            beatGo   = 1'b1;
            beatWr   = isWr;
            beatBank = pins.bankPickBit;
            beatCol0 = pins.rowAddressBus[COLS_W-1:0];
            beatCnt  = '0;
            beatAp   = pins.rowAddressBus[PCH_MODE_BIT];
            beatIlv  = mode_q[MR_BT_BIT];
            beatLen  = (isWr && mode_q[MR_WB_BIT]) ? 9'h001 : burstLen(mode_q[MR_BL_LSB +: 3]);
        end else if (edgeOk && burstOn_q && !isStop && !isPre) begin
            beatGo = 1'b1;
        end
        lastBeat = (beatLen != 9'h000) && ({1'b0, beatCnt} == beatLen - 9'h001);
        beatCol  = burstCol(beatCol0, beatCnt, beatLen, beatIlv);
        apFire   = beatGo && lastBeat && beatAp;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            burstOn_q   <= 1'b0;
            burstWr_q   <= 1'b0;
            burstBank_q <= 1'b0;
            burstAp_q   <= 1'b0;
            burstIlv_q  <= 1'b0;
            burstCol0_q <= '0;
            burstCnt_q  <= '0;
            burstLen_q  <= 9'h001;
        end else if (isRd || isWr) begin
            burstOn_q   <= !lastBeat;
            burstWr_q   <= beatWr;
            burstBank_q <= beatBank;
            burstAp_q   <= beatAp;
            burstIlv_q  <= beatIlv;
            burstCol0_q <= beatCol0;
            burstCnt_q  <= COLS_W'(1);
            burstLen_q  <= beatLen;
        end else if (isStop || isPre) begin
            burstOn_q <= 1'b0;
        end else if (beatGo) begin
            burstCnt_q <= burstCnt_q + COLS_W'(1);
            burstOn_q  <= !lastBeat;
        end
    end

    // ----------------------------------------------------------------
    // Banks
    // ----------------------------------------------------------------
    // independent bank state
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bankOpen_q <= '0;
            for (int b = 0; b < 2; b++) begin
                bankRow_q[b] <= '0;
            end
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (isAct && pins.bankPickBit == b[0]) begin
                    bankOpen_q[b] <= 1'b1;
                    bankRow_q[b]  <= pins.rowAddressBus[ROWS_W-1:0];
                end
                if (isPre && (pins.rowAddressBus[PCH_MODE_BIT] || pins.bankPickBit == b[0])) begin
                    bankOpen_q[b] <= 1'b0;
                end
                if (apFire && beatBank == b[0]) begin
                    bankOpen_q[b] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Array and read pipeline
    // ----------------------------------------------------------------
    localparam int DEPTH = 2 << (ROWS_W + COLS_W);
    logic [DATA_W-1:0]            mem [DEPTH];
    logic [ROWS_W+COLS_W:0]       memIdx;
    logic [DATA_W-1:0]            pipeD_q [2];
    logic [1:0]                   pipeOe_q [2];
    assign memIdx = {beatBank, bankRow_q[beatBank], beatCol};

    // masked bytes are not stored; per byte
    always_ff @(posedge mclk) begin
        if (beatGo && beatWr) begin
            if (!pins.lowByteMask) begin
                mem[memIdx][7:0] <= dataIn[7:0];
            end
            if (!pins.highByteMask) begin
                mem[memIdx][15:8] <= dataIn[15:8];
            end
        end
    end

    // The whole pipe freezes on an ignored edge, which is clock suspend.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pipeD_q[0]  <= '0;
            pipeD_q[1]  <= '0;
            pipeOe_q[0] <= '0;
            pipeOe_q[1] <= '0;
        end else if (edgeOk) begin
            pipeD_q[0]  <= mem[memIdx];
            pipeOe_q[0] <= (beatGo && !beatWr) ? ~{pins.highByteMask, pins.lowByteMask} : 2'b00;
            pipeD_q[1]  <= pipeD_q[0];
            pipeOe_q[1] <= pipeOe_q[0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dataOut <= '0;
            dataOe  <= '0;
        end else if (edgeOk) begin
            if (mode_q[MR_CL_LSB +: 3] == CL_THREE) begin
                dataOut <= pipeD_q[1];
                dataOe  <= pipeOe_q[1];
            end else begin
                dataOut <= pipeD_q[0];
                dataOe  <= pipeOe_q[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Power state and refresh count
    // ----------------------------------------------------------------
    // low gate state
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pwr_q <= PWR_RUN;
        end else if (cke) begin
            pwr_q <= PWR_RUN;
        end else if (edgeOk) begin
            if (isRef) begin
                pwr_q <= PWR_SELFREF;
            end else if (burstOn_q || pipeOe_q[0] != 2'b00 || pipeOe_q[1] != 2'b00) begin
                pwr_q <= PWR_SUSPEND;
            end else begin
                pwr_q <= PWR_DOWN;
            end
        end
    end

    // Only auto refresh counts; self refresh is internal and unseen.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            refCnt_q <= '0;
        end else if (isRef && cke) begin
            refCnt_q <= refCnt_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    logic       wrPend_q;
    logic [7:0] wrOfs_q;
    logic       addrPhase;
    assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);

    // Reads are answered with no wait state: data is latched at the
    // end of the address phase from the state at that edge.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wrPend_q  <= 1'b0;
            wrOfs_q   <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend_q  <= addrPhase && hwrite;
            wrOfs_q   <= haddr[7:0];
            hrdata    <= '0;
            if (addrPhase && !hwrite) begin
                case (haddr[7:0])
                    OFS_STATUS: hrdata <= {26'h0, burstOn_q, pwr_q[3:1], bankOpen_q};
                    OFS_MODE:   hrdata <= {20'h0, mode_q};
                    OFS_ROWS:   hrdata <= {5'h0, bankRow_q[1], 5'h0, bankRow_q[0]};
                    OFS_REFCNT: hrdata <= {16'h0, refCnt_q};
                    default:    hrdata <= '0;
                endcase
            end
        end
    end

    // opcode from address and bank pick; command beats software.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode_q <= MR_RESET;
        end else if (isMrs) begin
            mode_q <= {pins.bankPickBit, pins.rowAddressBus};
        end else if (wrPend_q && hready && wrOfs_q == OFS_MODE) begin
            mode_q <= hwdata[OPC_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence sRdCl2Open;
        isRd && mode_q[MR_CL_LSB +: 3] == CL_TWO && !pins.highByteMask && !pins.lowByteMask;
    endsequence
    sequence sRdCl2Masked;
        isRd && mode_q[MR_CL_LSB +: 3] == CL_TWO && pins.highByteMask && pins.lowByteMask;
    endsequence

    a_gate_freezes: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !edgeOk |=> $stable(burstOn_q) && $stable(bankOpen_q) && $stable(dataOe))
        else $error("Ignored edge changed state.");
    a_low_gate_state: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !cke_q |-> pwr_q != PWR_RUN)
        else $error("Gate low while running.");
    a_deselect_holds: assert property (
        @(posedge mclk) disable iff (!reset_n)
        pins.csN && !apFire |=> $stable(bankOpen_q))
        else $error("Deselected device changed bank state.");
    a_act_row_open: assert property (
        @(posedge mclk) disable iff (!reset_n)
        isAct && !pins.bankPickBit |=> bankOpen_q[0] && bankRow_q[0] == $past(pins.rowAddressBus))
        else $error("Activate did not open bank 0 row.");
    a_pch_all_banks: assert property (
        @(posedge mclk) disable iff (!reset_n)
        isPre && pins.rowAddressBus[PCH_MODE_BIT] |=> bankOpen_q == 2'b00)
        else $error("Precharge all left a bank open.");
    a_auto_pch_close: assert property (
        @(posedge mclk) disable iff (!reset_n)
        apFire && !isAct |=> !bankOpen_q[$past(beatBank)])
        else $error("Auto precharge did not close bank.");
    a_mrs_opcode: assert property (
        @(posedge mclk) disable iff (!reset_n)
        isMrs |=> mode_q == $past({pins.bankPickBit, pins.rowAddressBus}))
        else $error("Mode register not loaded.");
    a_read_cl2_data: assert property (
        @(posedge mclk) disable iff (!reset_n)
        sRdCl2Open ##1 edgeOk |=> dataOe == 2'b11)
        else $error("Read data not driven at latency two.");
    a_read_mask_float: assert property (
        @(posedge mclk) disable iff (!reset_n)
        sRdCl2Masked ##1 edgeOk |=> dataOe == 2'b00)
        else $error("Masked read byte was driven.");
    a_stop_ends: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (isStop || isPre) && !isRd && !isWr |=> !burstOn_q)
        else $error("Burst survived stop.");

endmodule

// ### sdc_host_model.sv
`timescale 1ns/100ps

module sdc_host_model
    import sdc_pkg::*;
(
    input  wire logic              mclk,
    output logic                   cke,
    output sdcPins_t               pins,
    output logic      [DATA_W-1:0] dataIn
);
    initial begin
        cke    = 1'b1;
        pins   = '1;
        dataIn = 16'h0000;
    end

    task automatic send(input logic [2:0] c, input logic b, input logic [10:0] a,
                        input logic [1:0] m, input logic [15:0] d, input logic cs);
        pins   <= '{cs, c[2], c[1], c[0], b, a, m[1], m[0]};
        dataIn <= d;
        @(posedge mclk);
    endtask

    // deselect between commands
    // Idle address and data lines toggle, so a design that trusts stale values is caught.
    // Refresh is issued only by the bench; the run is far shorter than one refresh period.
    task automatic nop(input logic [1:0] m);
        pins   <= '{1'b1, 1'b1, 1'b1, 1'b1, ~pins.bankPickBit, ~pins.rowAddressBus, m[1], m[0]};
        dataIn <= ~dataIn;
        @(posedge mclk);
    endtask

    task automatic gate(input logic v);
        cke <= v;
    endtask
endmodule

// ### sdc_device_tb.sv
`timescale 1ns/100ps

module sdc_device_tb;
    import sdc_pkg::*;
    logic              mclk, reset_n, cke, hsel, hwrite, hready, hreadyout, hresp;
    sdcPins_t          pins;
    logic [DATA_W-1:0] dataIn, dataOut, d;
    logic [1:0]        dataOe, htrans;
    logic [2:0]        hsize;
    logic [31:0]       haddr, hwdata, hrdata, rd;
    logic [10:0]       r0, r1;
    logic [7:0]        c;
    logic [11:0]       op;
    logic [15:0]       mem [256];
    logic [2:0]        bls [4] = '{BL_ONE, BL_TWO, BL_FOUR, BL_EIGHT};
    int                failures, checks_done;

    assign hready = hreadyout;

    sdc_host_model u_sdc_host_model (.mclk(mclk), .cke(cke), .pins(pins), .dataIn(dataIn));

    sdc_device u_sdc_device (
        .mclk(mclk), .reset_n(reset_n), .cke(cke), .pins(pins), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
            failures++;
        end
    endtask

    // The wait for hready is bounded, so a stuck slave ends the run instead of hanging it.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int   n;
        logic ok;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do begin @(posedge mclk); n++; end while (!hready && n < 16);
        ok = hready;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge mclk); n++; end while (!hready && n < 32);
        q = hrdata;
        if (!(ok && hready)) begin
            $display("MISMATCH %0t bus wait timed out", $time);
            failures++;
            complete_run();
        end
    endtask

    function automatic logic [7:0] col_at(input logic [7:0] s, input int i,
                                          input logic [2:0] bl, input logic il);
        int len;
        len = (bl == BL_PAGE) ? 256 : (1 << bl);
        if (il && bl != BL_PAGE) return 8'((s & ~(len - 1)) | ((s ^ i) & (len - 1)));
        return 8'((s & ~(len - 1)) | ((s + i) & (len - 1)));
    endfunction

    task automatic cmd(input logic [2:0] k, input logic b, input logic [10:0] a,
                       input logic [15:0] wd, input logic cs);
        u_sdc_host_model.send(k, b, a, 2'b00, wd, cs);
    endtask

    task automatic idle();
        u_sdc_host_model.nop(2'b00);
    endtask

    task automatic wr(input logic [7:0] k, input logic [15:0] wd, input logic [1:0] m);
        u_sdc_host_model.send(CMD_WR, 1'b0, {3'b000, k}, m, wd, 1'b0);
        mem[k] = {m[1] ? mem[k][15:8] : wd[15:8], m[0] ? mem[k][7:0] : wd[7:0]};
    endtask

    task automatic setmode(input logic [11:0] o);
        cmd(CMD_MRS, o[11], o[10:0], 16'h0000, 1'b0);
        idle();
    endtask

    // Masked read bytes may carry anything, so only enabled bytes are compared.
    task automatic rd_burst(input logic [7:0] s, input int n, input int lat,
                            input logic [2:0] bl, input logic il, input logic [1:0] m,
                            input logic stp);
        logic [15:0] en;
        en = {{8{~m[1]}}, {8{~m[0]}}};
        u_sdc_host_model.send(CMD_RD, 1'b0, {3'b000, s}, m, 16'h0000, 1'b0);
        repeat (lat - 1) u_sdc_host_model.nop(m);
        for (int i = 0; i < n; i++) begin
            u_sdc_host_model.nop(m);
            check({16'h0, dataOut & en}, {16'h0, mem[col_at(s, i, bl, il)] & en}, "beat");
            check({30'h0, dataOe}, {30'h0, ~m}, "beat enables");
        end
        if (stp) begin
            u_sdc_host_model.send(CMD_STOP, 1'b0, 11'h000, m, 16'h0000, 1'b0);
            repeat (lat - 1) u_sdc_host_model.nop(m);
        end
        u_sdc_host_model.nop(m);
        check({30'h0, dataOe}, 32'h0, "burst end");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    // the 40 ns period stays below the rated maximum
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        failures = 0;
        checks_done = 0;
        void'($urandom(8));
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        ahb(1'b0, OFS_MODE, 32'h0, rd);
        check(rd, {20'h0_0000, MR_RESET}, "mode reset");
        ahb(1'b1, OFS_STATUS, 32'hFFFF_FFFF, rd);
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        check(rd, 32'h0, "status read only");
        ahb(1'b0, 8'h10, 32'h0, rd);
        check({rd[31:1], hresp}, 32'h0, "unmapped");
        $display("test registers done");
        op = {1'b1, 11'($urandom)};
        setmode(op);
        ahb(1'b0, OFS_MODE, 32'h0, rd);
        check(rd, {20'h0_0000, op}, "opcode");
        setmode(12'h020);
        r0 = 11'($urandom);
        r1 = 11'($urandom);
        cmd(CMD_ACT, 1'b0, r0, 16'h0000, 1'b0);
        cmd(CMD_ACT, 1'b1, r1, 16'h0000, 1'b0);
        idle();
        ahb(1'b0, OFS_ROWS, 32'h0, rd);
        check(rd, {5'h00, r1, 5'h00, r0}, "rows");
        $display("test activate done");
        for (int i = 0; i < 256; i++) wr(8'(i), 16'($urandom), 2'b00);
        repeat (32) wr(8'($urandom), 16'($urandom), 2'($urandom));
        cmd(CMD_WR, 1'b0, 11'h005, ~mem[5], 1'b1);
        u_sdc_host_model.gate(1'b0);
        idle();
        u_sdc_host_model.gate(1'b1);
        cmd(CMD_WR, 1'b0, 11'h006, ~mem[6], 1'b0);
        idle();
        rd_burst(8'h05, 1, 2, BL_ONE, 1'b0, 2'b00, 1'b0);
        rd_burst(8'h06, 1, 2, BL_ONE, 1'b0, 2'b00, 1'b0);
        rd_burst(8'h07, 1, 2, BL_ONE, 1'b0, 2'b11, 1'b0);
        $display("test writes done");
        foreach (bls[j]) begin
            for (int v = 0; v < 4; v++) begin
                setmode({5'h00, v[1] ? CL_THREE : CL_TWO, v[0], bls[j]});
                rd_burst(8'($urandom), 1 << bls[j], v[1] ? 3 : 2, bls[j], v[0],
                         2'($urandom), 1'b0);
            end
        end
        ahb(1'b1, OFS_MODE, 32'h0000_0027, rd);
        ahb(1'b0, OFS_MODE, 32'h0, rd);
        check(rd, 32'h0000_0027, "mode write");
        rd_burst(8'hFA, 10, 2, BL_PAGE, 1'b0, 2'b00, 1'b1);
        setmode(12'h020);
        cmd(CMD_RD, 1'b0, 11'h011, 16'h0000, 1'b0);
        rd_burst(8'h12, 1, 2, BL_ONE, 1'b0, 2'b00, 1'b0);
        $display("test reads done");
        setmode(12'h222);
        c = 8'($urandom) & 8'hF8;
        wr(c, 16'($urandom), 2'b00);
        repeat (3) idle();
        setmode(12'h022);
        rd_burst(c, 4, 2, BL_FOUR, 1'b0, 2'b00, 1'b0);
        $display("test single writes done");
        setmode(12'h020);
        cmd(CMD_WR, 1'b1, 11'h400, 16'h1234, 1'b0);
        repeat (4) idle();
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        check({30'h0, rd[1:0]}, 32'h1, "auto precharge");
        cmd(CMD_ACT, 1'b1, r1, 16'h0000, 1'b0);
        cmd(CMD_PRE, 1'b0, 11'h000, 16'h0000, 1'b0);
        idle();
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        check({30'h0, rd[1:0]}, 32'h2, "one bank");
        cmd(CMD_ACT, 1'b0, r0, 16'h0000, 1'b0);
        cmd(CMD_PRE, 1'b0, 11'h400, 16'h0000, 1'b0);
        idle();
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        check({30'h0, rd[1:0]}, 32'h0, "both banks");
        cmd(CMD_REF, 1'b0, 11'h000, 16'h0000, 1'b0);
        cmd(CMD_REF, 1'b0, 11'h000, 16'h0000, 1'b0);
        idle();
        ahb(1'b0, OFS_REFCNT, 32'h0, rd);
        check(rd, 32'h2, "refresh count");
        u_sdc_host_model.gate(1'b0);
        cmd(CMD_REF, 1'b0, 11'h000, 16'h0000, 1'b0);
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        check({29'h0, rd[4:2]}, 32'h4, "self refresh");
        u_sdc_host_model.gate(1'b1);
        idle();
        ahb(1'b0, OFS_REFCNT, 32'h0, rd);
        check(rd, 32'h2, "no count in self refresh");
        $display("test precharge done");
        complete_run();
    end
endmodule
